// >>> hw/arcs_defines.svh
/*
 * Constants of the configuration and status register block: field
 * positions, reset value and divider counts.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef ARCS_DEFINES_SVH
`define ARCS_DEFINES_SVH

`define ARCS_CR_RX1_RATE 0
`define ARCS_CR_LABEL_ACCESS 1
`define ARCS_CR_RX1_FILTER 2
`define ARCS_CR_RX2_FILTER 3
`define ARCS_CR_TX_PARITY_SEL 4
`define ARCS_CR_SELF_TEST_N 5
`define ARCS_CR_RX1_DEC_EN 6
`define ARCS_CR_RX1_MATCH9 7
`define ARCS_CR_RX1_MATCH10 8
`define ARCS_CR_RX2_DEC_EN 9
`define ARCS_CR_RX2_MATCH9 10
`define ARCS_CR_RX2_MATCH10 11
`define ARCS_CR_TX_PARITY_INV 12
`define ARCS_CR_TX_RATE 13
`define ARCS_CR_RX2_RATE 14
`define ARCS_CR_DATA_FORMAT 15

`define ARCS_SR_RX1_READY 0
`define ARCS_SR_RX1_HALF 1
`define ARCS_SR_RX1_FULL 2
`define ARCS_SR_RX2_READY 3
`define ARCS_SR_RX2_HALF 4
`define ARCS_SR_RX2_FULL 5
`define ARCS_SR_TX_EMPTY 6
`define ARCS_SR_TX_FULL 7
`define ARCS_SR_TX_HALF 8

`define ARCS_CFG_RESET 16'h0000
`define ARCS_DIV_FAST 10
`define ARCS_DIV_SLOW 80
`define ARCS_HALF_LEVEL 16
`define ARCS_FIFO_DEPTH 32
`define ARCS_LABELS 16

`endif

// >>> hw/arcs_label_mem.sv
/*
 * Label memory of one receiver: write port, registered read port
 * and registered match of a label against every stored entry.
 * Assumes synchronous inputs on the system clock.
 */
`timescale 1ns/10ps
`include "arcs_defines.svh"

module arcs_label_mem #(
	parameter int DEPTH = `ARCS_LABELS,
	parameter int WIDTH = 8,
	parameter int AW = 4
) (
	input wire logic i_clk_sys, // System clock
	input wire logic i_rst_n, // Async reset, low
	input wire logic i_we, // Write strobe
	input wire logic [AW-1:0] i_addr, // Read/write address
	input wire logic [WIDTH-1:0] i_wdata, // Write data
	input wire logic [WIDTH-1:0] i_label, // Label to match
	output logic [WIDTH-1:0] o_rdata, // Registered read data
	output logic o_hit // Registered match
);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [WIDTH-1:0] rdata;
		logic hit;
	} arcs_mem_s;

	arcs_mem_s st;
	arcs_mem_s next_st;

	always_comb begin
		next_st = st;
		if (i_we) begin
			next_st.mem[i_addr] = i_wdata;
		end
		next_st.rdata = st.mem[i_addr];
		next_st.hit = 1'b0;
		for (int i = 0; i < DEPTH; i++) begin
			if (st.mem[i] == i_label) begin
				next_st.hit = 1'b1;
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_rdata = st.rdata;
	assign o_hit = st.hit;

endmodule

// >>> hw/arcs_pkg.sv
/*
 * Types shared by the register block and its divider.
 * Assumes the defines header for field positions.
 */
package arcs_pkg;

	typedef enum logic [1:0] {
		ARCS_SRC_NONE = 2'b00,
		ARCS_SRC_CFG = 2'b01,
		ARCS_SRC_STAT = 2'b10,
		ARCS_SRC_RX = 2'b11
	} arcs_src_e;

	typedef struct packed {
		logic [6:0] cnt;
		logic en;
		logic slow;
	} arcs_div_s;

	typedef struct packed {
		logic [15:0] cfg;
		logic pl1_d;
		logic pl2_d;
		logic en1_d;
		logic en2_d;
		logic [15:0] tx_low;
		logic [3:0] ptr1;
		logic [3:0] ptr2;
		logic [1:0] eos_d;
		logic [1:0] load;
		logic [15:0] bus_data;
		logic bus_oe_n;
		logic [8:0] status;
		logic [8:0] pins_n;
		logic [1:0] rx_one;
		logic [1:0] rx_zero;
		logic [31:0] tx_word;
		logic tx_valid;
	} arcs_top_s;

endpackage

// >>> hw/arcs_rate_div.sv
/*
 * Rate divider: one-cycle enable every FAST or SLOW clocks.
 * Assumes a single clock; the rate select may change at any time.
 */
`timescale 1ns/10ps
`include "arcs_defines.svh"

module arcs_rate_div #(
	parameter int FAST = `ARCS_DIV_FAST,
	parameter int SLOW = `ARCS_DIV_SLOW
) (
	input wire logic i_clk_sys, // System clock
	input wire logic i_rst_n, // Async reset, low
	input wire logic i_slow, // 1 selects SLOW
	output logic o_en, // Rate enable pulse
	output logic o_slow // Registered rate select
);

	arcs_pkg::arcs_div_s st;
	arcs_pkg::arcs_div_s next_st;
	logic [6:0] last;

	always_comb begin
		next_st = st;
		last = i_slow ? 7'(SLOW - 1) : 7'(FAST - 1);
		next_st.slow = i_slow;
		next_st.en = 1'b0;
		if (st.cnt >= last) begin
			next_st.cnt = 7'h00;
			next_st.en = 1'b1;
		end else begin
			next_st.cnt = st.cnt + 7'h01;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_en = st.en;
	assign o_slow = st.slow;

endmodule

// >>> hw/arcs_regs.sv
/*
 * Configuration word, status word and their host bus of a dual
 * receiver, single transmitter serial interface, plus the logic the
 * configuration steers: rate enables, loopback, word filtering,
 * transmit 32nd bit and bus bit mapping.
 * Assumes all inputs synchronous to i_clk_sys; FIFOs, samplers and
 * the serialiser sit outside and report FIFO fill counts here.
 */
`timescale 1ns/10ps
`include "arcs_defines.svh"

module arcs_regs #(
	parameter int CNT_W = 6,
	parameter int DEPTH = `ARCS_FIFO_DEPTH,
	parameter int HALF = `ARCS_HALF_LEVEL
) (
	input wire logic i_clk_sys, // System clock
	input wire logic i_rst_n, // Async reset, low
	input wire logic [15:0] i_bus_data, // Host data bus in
	output logic [15:0] o_bus_data, // Host data bus out
	output logic o_bus_oe_n, // Bus drive, low drives
	input wire logic i_config_write_strobe_n, // Config write
	input wire logic i_register_read_strobe_n, // Register read
	input wire logic i_byte_select, // 0 status/byte1
	input wire logic i_tx_low_half_latch_n, // Tx low half latch
	input wire logic i_tx_high_half_latch_n, // Tx high half latch
	input wire logic i_rx1_read_enable_n, // Rx1 read
	input wire logic i_rx2_read_enable_n, // Rx2 read
	input wire logic [CNT_W-1:0] i_rx1_count, // Rx1 FIFO level
	input wire logic [CNT_W-1:0] i_rx2_count, // Rx2 FIFO level
	input wire logic [CNT_W-1:0] i_tx_count, // Tx FIFO level
	input wire logic [31:0] i_rx1_word, // Rx1 FIFO head
	input wire logic [31:0] i_rx2_word, // Rx2 FIFO head
	input wire logic [31:0] i_rx1_rcv_word, // Rx1 new word
	input wire logic [31:0] i_rx2_rcv_word, // Rx2 new word
	input wire logic i_rx1_eos, // Rx1 word complete
	input wire logic i_rx2_eos, // Rx2 word complete
	input wire logic i_rx1_line_one, // Rx1 line ones
	input wire logic i_rx1_line_zero, // Rx1 line zeros
	input wire logic i_rx2_line_one, // Rx2 line ones
	input wire logic i_rx2_line_zero, // Rx2 line zeros
	input wire logic i_tx_out_one, // Tx digital ones
	input wire logic i_tx_out_zero, // Tx digital zeros
	output logic o_rx1_one, // Rx1 logic ones in
	output logic o_rx1_zero, // Rx1 logic zeros in
	output logic o_rx2_one, // Rx2 logic ones in
	output logic o_rx2_zero, // Rx2 logic zeros in
	output logic o_rx1_load, // Rx1 word accepted
	output logic o_rx2_load, // Rx2 word accepted
	output logic [31:0] o_tx_word, // Tx word to FIFO
	output logic o_tx_word_valid, // Tx word strobe
	output logic o_tx_clk_en, // Tx bit enable
	output logic o_tx_slow_slope, // Tx slow slope
	output logic o_rx1_sample_en, // Rx1 sample enable
	output logic o_rx2_sample_en, // Rx2 sample enable
	output logic o_rx1_ready_pin_n, // Rx1 data ready
	output logic o_rx1_half_pin_n, // Rx1 half full
	output logic o_rx1_full_pin_n, // Rx1 full
	output logic o_rx2_ready_pin_n, // Rx2 data ready
	output logic o_rx2_half_pin_n, // Rx2 half full
	output logic o_rx2_full_pin_n, // Rx2 full
	output logic o_tx_full_pin_n, // Tx full
	output logic o_tx_half_pin_n // Tx half full
);

	arcs_pkg::arcs_top_s st;
	arcs_pkg::arcs_top_s next_st;
	arcs_pkg::arcs_src_e src;

	logic [2:0] rate_sel;
	logic [2:0] rate_en;
	logic [2:0] rate_slow;
	logic [1:0] lbl_we;
	logic [1:0][3:0] lbl_addr;
	logic [1:0][7:0] lbl_rdata;
	logic [1:0][7:0] lbl_match;
	logic [1:0] lbl_hit;
	logic pl1_fall;
	logic pl2_fall;
	logic en1_rise;
	logic en2_rise;
	logic [31:0] asm_word;
	logic [15:0] rd_data;
	logic [1:0] accept;

	function automatic logic fell(input logic prev, input logic cur);
		fell = prev & ~cur;
	endfunction

	function automatic logic [7:0] rev8(input logic [7:0] v);
		for (int i = 0; i < 8; i++) begin
			rev8[i] = v[7-i];
		end
	endfunction

	function automatic logic [15:0] map_half(input logic fmt,
			input logic hi, input logic [31:0] w);
		if (fmt) begin
			map_half = hi ? w[31:16] : w[15:0];
		end else if (hi) begin
			map_half = w[28:13];
		end else begin
			map_half = {w[12:8], w[30], w[29], w[31], rev8(w[7:0])};
		end
	endfunction

	function automatic logic [31:0] unmap(input logic fmt,
			input logic [15:0] b1, input logic [15:0] b2);
		if (fmt) begin
			unmap = {b2, b1};
		end else begin
			unmap = {b1[8], b1[10], b1[9], b2, b1[15:11], rev8(b1[7:0])};
		end
	endfunction

	function automatic logic [2:0] levels(input logic [CNT_W-1:0] c);
		levels[0] = (c != '0);
		levels[1] = (c >= CNT_W'(HALF));
		levels[2] = (c >= CNT_W'(DEPTH));
	endfunction

	assign rate_sel = {st.cfg[`ARCS_CR_RX2_RATE],
		st.cfg[`ARCS_CR_RX1_RATE], st.cfg[`ARCS_CR_TX_RATE]};

	generate
		for (genvar g = 0; g < 3; g++) begin : g_div
			arcs_rate_div u_div (
				.i_clk_sys(i_clk_sys),
				.i_rst_n(i_rst_n),
				.i_slow(rate_sel[g]),
				.o_en(rate_en[g]),
				.o_slow(rate_slow[g])
			);
		end
		for (genvar g = 0; g < 2; g++) begin : g_lbl
			arcs_label_mem u_mem (
				.i_clk_sys(i_clk_sys),
				.i_rst_n(i_rst_n),
				.i_we(lbl_we[g]),
				.i_addr(lbl_addr[g]),
				.i_wdata(i_bus_data[7:0]),
				.i_label(lbl_match[g]),
				.o_rdata(lbl_rdata[g]),
				.o_hit(lbl_hit[g])
			);
		end
	endgenerate

	assign pl1_fall = fell(st.pl1_d, i_tx_low_half_latch_n);
	assign pl2_fall = fell(st.pl2_d, i_tx_high_half_latch_n);
	assign en1_rise = fell(i_rx1_read_enable_n, st.en1_d);
	assign en2_rise = fell(i_rx2_read_enable_n, st.en2_d);

	assign lbl_we[0] = st.cfg[`ARCS_CR_LABEL_ACCESS] & pl1_fall;
	assign lbl_we[1] = st.cfg[`ARCS_CR_LABEL_ACCESS] & pl2_fall;
	assign lbl_addr[0] = st.ptr1;
	assign lbl_addr[1] = st.ptr2;
	assign lbl_match[0] = i_rx1_rcv_word[7:0];
	assign lbl_match[1] = i_rx2_rcv_word[7:0];

	assign accept[0] = (~st.cfg[`ARCS_CR_RX1_FILTER] | lbl_hit[0]) &
		(~st.cfg[`ARCS_CR_RX1_DEC_EN] | (i_rx1_rcv_word[9:8] ==
		{st.cfg[`ARCS_CR_RX1_MATCH10], st.cfg[`ARCS_CR_RX1_MATCH9]}));
	assign accept[1] = (~st.cfg[`ARCS_CR_RX2_FILTER] | lbl_hit[1]) &
		(~st.cfg[`ARCS_CR_RX2_DEC_EN] | (i_rx2_rcv_word[9:8] ==
		{st.cfg[`ARCS_CR_RX2_MATCH10], st.cfg[`ARCS_CR_RX2_MATCH9]}));

	always_comb begin
		next_st = st;
		asm_word = unmap(st.cfg[`ARCS_CR_DATA_FORMAT], st.tx_low,
			i_bus_data);
		rd_data = 16'h0000;
		if (!i_register_read_strobe_n) begin
			src = i_byte_select ? arcs_pkg::ARCS_SRC_CFG :
				arcs_pkg::ARCS_SRC_STAT;
		end else if (!i_rx1_read_enable_n || !i_rx2_read_enable_n) begin
			src = arcs_pkg::ARCS_SRC_RX;
		end else begin
			src = arcs_pkg::ARCS_SRC_NONE;
		end

		if (!i_config_write_strobe_n) begin
			next_st.cfg = i_bus_data;
		end

		next_st.pl1_d = i_tx_low_half_latch_n;
		next_st.pl2_d = i_tx_high_half_latch_n;
		next_st.en1_d = i_rx1_read_enable_n;
		next_st.en2_d = i_rx2_read_enable_n;

		// label pointers step after each access
		if (st.cfg[`ARCS_CR_LABEL_ACCESS]) begin
			if (pl1_fall || en1_rise) begin
				next_st.ptr1 = st.ptr1 + 4'h1;
			end
			if (pl2_fall || en2_rise) begin
				next_st.ptr2 = st.ptr2 + 4'h1;
			end
		end else begin
			next_st.ptr1 = 4'h0;
			next_st.ptr2 = 4'h0;
		end

		// Transmit word assembly from two halves
		next_st.tx_valid = 1'b0;
		if (!st.cfg[`ARCS_CR_LABEL_ACCESS]) begin
			if (pl1_fall) begin
				next_st.tx_low = i_bus_data;
			end
			if (pl2_fall) begin
				next_st.tx_word = asm_word;
				if (st.cfg[`ARCS_CR_TX_PARITY_SEL]) begin
					next_st.tx_word[31] = ~(^asm_word[30:0]) ^
						st.cfg[`ARCS_CR_TX_PARITY_INV];
				end
				next_st.tx_valid = 1'b1;
			end
		end

		// Word accepted once label match has settled
		next_st.eos_d = {i_rx2_eos, i_rx1_eos};
		next_st.load = st.eos_d & accept;

		next_st.status[2:0] = levels(i_rx1_count);
		next_st.status[5:3] = levels(i_rx2_count);
		next_st.status[`ARCS_SR_TX_EMPTY] = (i_tx_count == '0);
		next_st.status[`ARCS_SR_TX_FULL] = (i_tx_count >= CNT_W'(DEPTH));
		next_st.status[`ARCS_SR_TX_HALF] = (i_tx_count >= CNT_W'(HALF));
		next_st.pins_n = ~next_st.status;

		if (st.cfg[`ARCS_CR_SELF_TEST_N]) begin
			next_st.rx_one = {i_rx2_line_one, i_rx1_line_one};
			next_st.rx_zero = {i_rx2_line_zero, i_rx1_line_zero};
		end else begin
			next_st.rx_one = {2{i_tx_out_one}};
			next_st.rx_zero = {2{i_tx_out_zero}};
		end

		case (src)
			arcs_pkg::ARCS_SRC_CFG: begin
				rd_data = st.cfg;
			end
			arcs_pkg::ARCS_SRC_STAT: begin
				rd_data = {7'h00, st.status};
			end
			arcs_pkg::ARCS_SRC_RX: begin
				if (st.cfg[`ARCS_CR_LABEL_ACCESS]) begin
					rd_data = {8'h00, !i_rx1_read_enable_n ?
						lbl_rdata[0] : lbl_rdata[1]};
				end else begin
					rd_data = map_half(st.cfg[`ARCS_CR_DATA_FORMAT],
						i_byte_select, !i_rx1_read_enable_n ?
						i_rx1_word : i_rx2_word);
				end
			end
			default: begin
				rd_data = 16'h0000;
			end
		endcase
		next_st.bus_data = rd_data;
		next_st.bus_oe_n = (src == arcs_pkg::ARCS_SRC_NONE);
	end

	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= '0;
			st.cfg <= `ARCS_CFG_RESET;
			st.pl1_d <= 1'b1;
			st.pl2_d <= 1'b1;
			st.en1_d <= 1'b1;
			st.en2_d <= 1'b1;
			st.bus_oe_n <= 1'b1;
			st.status <= 9'h040;
			st.pins_n <= 9'h1BF;
		end else begin
			st <= next_st;
		end
	end

	assign o_bus_data = st.bus_data;
	assign o_bus_oe_n = st.bus_oe_n;
	assign o_rx1_one = st.rx_one[0];
	assign o_rx1_zero = st.rx_zero[0];
	assign o_rx2_one = st.rx_one[1];
	assign o_rx2_zero = st.rx_zero[1];
	assign o_rx1_load = st.load[0];
	assign o_rx2_load = st.load[1];
	assign o_tx_word = st.tx_word;
	assign o_tx_word_valid = st.tx_valid;
	assign o_tx_clk_en = rate_en[0];
	assign o_tx_slow_slope = rate_slow[0];
	assign o_rx1_sample_en = rate_en[1];
	assign o_rx2_sample_en = rate_en[2];
	assign o_rx1_ready_pin_n = st.pins_n[`ARCS_SR_RX1_READY];
	assign o_rx1_half_pin_n = st.pins_n[`ARCS_SR_RX1_HALF];
	assign o_rx1_full_pin_n = st.pins_n[`ARCS_SR_RX1_FULL];
	assign o_rx2_ready_pin_n = st.pins_n[`ARCS_SR_RX2_READY];
	assign o_rx2_half_pin_n = st.pins_n[`ARCS_SR_RX2_HALF];
	assign o_rx2_full_pin_n = st.pins_n[`ARCS_SR_RX2_FULL];
	assign o_tx_full_pin_n = st.pins_n[`ARCS_SR_TX_FULL];
	assign o_tx_half_pin_n = st.pins_n[`ARCS_SR_TX_HALF];

endmodule

// >>> tb/arcs_host_model.sv
/*
 * Host processor model on the 16-bit bus: writes, reads, tx latches.
 * Assumes the bench calls its tasks; drives 5 ns after rising edges.
 */
`timescale 1ns/10ps

module arcs_host_model (
	input wire logic i_clk_sys, // Clock
	input wire logic [15:0] i_bus_data, // Device bus out
	output logic [15:0] o_bus_data, // Host bus out
	output logic o_cw_n, // Config write strobe
	output logic o_rsr_n, // Register read strobe
	output logic o_sel, // Byte select
	output logic o_pl1_n, // Low half latch
	output logic o_pl2_n, // High half latch
	output logic o_en1_n, // Rx1 read enable
	output logic o_en2_n // Rx2 read enable
);
	initial begin
		o_bus_data = 16'h0000;
		{o_cw_n, o_rsr_n, o_sel, o_pl1_n, o_pl2_n} = 5'h1B;
		{o_en1_n, o_en2_n} = 2'b11;
	end

	// Receiver read, enable held two edges for the registered label read
	task automatic rx(input logic s, input logic r2, output logic [15:0] q);
		@(posedge i_clk_sys) #5;
		o_sel = s;
		if (r2)
			o_en2_n = 1'b0;
		else
			o_en1_n = 1'b0;
		@(posedge i_clk_sys);
		@(posedge i_clk_sys) #1;
		q = i_bus_data;
		#4 {o_en1_n, o_en2_n} = 2'b11;
	endtask

	task automatic wr(input logic [15:0] d);
		@(posedge i_clk_sys) #5;
		o_bus_data = d;
		o_cw_n = 1'b0;
		@(posedge i_clk_sys) #5;
		o_cw_n = 1'b1;
		o_bus_data = ~d;
	endtask

	task automatic rd(input logic s, output logic [15:0] q);
		@(posedge i_clk_sys) #5;
		o_sel = s;
		o_rsr_n = 1'b0;
		@(posedge i_clk_sys) #1;
		q = i_bus_data;
		#4 o_rsr_n = 1'b1;
	endtask

	// Low half first, then high half
	task automatic tx(input logic [15:0] h1, input logic [15:0] h2);
		@(posedge i_clk_sys) #5;
		o_bus_data = h1;
		o_pl1_n = 1'b0;
		@(posedge i_clk_sys) #5;
		o_pl1_n = 1'b1;
		o_bus_data = h2;
		o_pl2_n = 1'b0;
		@(posedge i_clk_sys) #5;
		o_pl2_n = 1'b1;
		o_bus_data = ~h2;
	endtask
endmodule

// >>> tb/arcs_regs_bench.sv
/*
 * Self-checking bench of the register block, host model on the bus.
 * Assumes a 20 MHz clock; FIFO levels and receiver events come from here.
 */
`timescale 1ns/10ps

module arcs_regs_bench;
	logic i_clk_sys, i_rst_n, cw_n, rsr_n, sel, pl1_n, pl2_n;
	logic [15:0] hbus, dbus, q;
	logic [5:0] c1, c2, ct;
	logic [31:0] w1, w2, tw;
	logic eos1, eos2, l1o, l1z, l2o, l2z, to, tz, tv, ten, e1, e2, slope;
	logic r1o, r1z, r2o, r2z, ld1, ld2, oe, en1_n, en2_n;
	logic [31:0] hw1, hw2;
	logic [1:0] lv;
	logic [7:0] pn;
	int miscompares, total_checks, cyc, g;

	arcs_host_model u_host (.i_clk_sys(i_clk_sys), .i_bus_data(dbus),
		.o_bus_data(hbus), .o_cw_n(cw_n), .o_rsr_n(rsr_n), .o_sel(sel),
		.o_pl1_n(pl1_n), .o_pl2_n(pl2_n), .o_en1_n(en1_n),
		.o_en2_n(en2_n));

	arcs_regs u_dut (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
		.i_bus_data(hbus), .o_bus_data(dbus), .o_bus_oe_n(oe),
		.i_config_write_strobe_n(cw_n), .i_register_read_strobe_n(rsr_n),
		.i_byte_select(sel), .i_tx_low_half_latch_n(pl1_n),
		.i_tx_high_half_latch_n(pl2_n), .i_rx1_read_enable_n(en1_n),
		.i_rx2_read_enable_n(en2_n), .i_rx1_count(c1), .i_rx2_count(c2),
		.i_tx_count(ct), .i_rx1_word(hw1), .i_rx2_word(hw2),
		.i_rx1_rcv_word(w1), .i_rx2_rcv_word(w2), .i_rx1_eos(eos1),
		.i_rx2_eos(eos2), .i_rx1_line_one(l1o), .i_rx1_line_zero(l1z),
		.i_rx2_line_one(l2o), .i_rx2_line_zero(l2z), .i_tx_out_one(to),
		.i_tx_out_zero(tz), .o_rx1_one(r1o), .o_rx1_zero(r1z),
		.o_rx2_one(r2o), .o_rx2_zero(r2z), .o_rx1_load(ld1),
		.o_rx2_load(ld2), .o_tx_word(tw), .o_tx_word_valid(tv),
		.o_tx_clk_en(ten), .o_tx_slow_slope(slope), .o_rx1_sample_en(e1),
		.o_rx2_sample_en(e2), .o_rx1_ready_pin_n(pn[0]),
		.o_rx1_half_pin_n(pn[1]), .o_rx1_full_pin_n(pn[2]),
		.o_rx2_ready_pin_n(pn[3]), .o_rx2_half_pin_n(pn[4]),
		.o_rx2_full_pin_n(pn[5]), .o_tx_full_pin_n(pn[6]),
		.o_tx_half_pin_n(pn[7]));

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	function automatic logic [2:0] st(input int v);
		return {v >= 32, v >= 16, v != 0};
	endfunction

	function automatic logic en(input int s);
		return s == 0 ? ten : (s == 1 ? e1 : e2);
	endfunction

	// Second interval between enable pulses
	task automatic gap_of(input int s, output int n);
		repeat (2) begin
			n = 0;
			do begin
				@(posedge i_clk_sys) #1;
				n++;
			end while (en(s) !== 1'b1 && n < 200);
		end
	endtask

	// Word received on both receivers, loads seen two edges on
	task automatic rcv(input logic [31:0] w, output logic [1:0] l);
		@(posedge i_clk_sys) #5;
		{eos1, eos2} = 2'b11;
		w1 = w;
		w2 = w;
		@(posedge i_clk_sys) #5;
		{eos1, eos2} = 2'b00;
		@(posedge i_clk_sys) #1;
		l = {ld2, ld1};
	endtask

	task automatic t_reset();
		u_host.rd(1'b1, q);
		chk(q, 16'h0000);
		chk(oe, 1'b0);
		@(posedge i_clk_sys) #1;
		chk(oe, 1'b1);
		u_host.rd(1'b0, q);
		chk(q, 16'h0040);
		$display("test reset done");
	endtask

	task automatic t_cfg();
		logic [15:0] v[4] = '{16'hA5C3, 16'h5A3C, 16'hFFFF, 16'h0001};
		foreach (v[i]) begin
			u_host.wr(v[i]);
			u_host.rd(1'b1, q);
			chk(q, v[i]);
		end
		$display("test config done");
	endtask

	task automatic t_stat();
		int n[6] = '{0, 1, 15, 16, 31, 32};
		logic [7:0] pe;
		foreach (n[i]) begin
			@(posedge i_clk_sys) #5;
			c1 = 6'(n[i]);
			c2 = 6'(32 - n[i]);
			ct = 6'(n[i]);
			u_host.rd(1'b0, q);
			chk(q, {7'h00, n[i] >= 16, n[i] >= 32, n[i] == 0,
				st(32 - n[i]), st(n[i])});
			pe = ~{n[i] >= 16, n[i] >= 32, st(32 - n[i]), st(n[i])};
			chk(pn, pe);
		end
		$display("test status done");
	endtask

	task automatic t_tx();
		for (int k = 0; k < 3; k++) begin
			u_host.wr({1'b1, 2'b00, k[0], 6'h00, 1'b1, k < 2, 4'h0});
			u_host.tx(16'h1234, 16'h8567);
			chk(tv, 1'b1);
			chk(tw[30:0], 31'h05671234);
			if (k < 2)
				chk(^tw, !k[0]);
			else
				chk(tw, 32'h85671234);
		end
		$display("test transmit done");
	endtask

	task automatic t_rate();
		u_host.wr(16'h6020);
		gap_of(0, g);
		chk(g, 80);
		chk(slope, 1'b1);
		gap_of(1, g);
		chk(g, 10);
		gap_of(2, g);
		chk(g, 80);
		u_host.wr(16'h0021);
		gap_of(0, g);
		chk(g, 10);
		gap_of(1, g);
		chk(g, 80);
		$display("test rates done");
	endtask

	task automatic t_loop();
		u_host.wr(16'h0000);
		{to, tz, l1o, l1z, l2o, l2z} = 6'b100110;
		repeat (2) @(posedge i_clk_sys);
		#1 chk({r1o, r1z, r2o, r2z}, 4'hA);
		u_host.wr(16'h0020);
		repeat (2) @(posedge i_clk_sys);
		#1 chk({r1o, r1z, r2o, r2z}, 4'h6);
		$display("test self test done");
	endtask

	task automatic t_dec();
		logic [1:0] b[4] = '{2'b01, 2'b10, 2'b11, 2'b11};
		logic [1:0] e[4] = '{2'b01, 2'b10, 2'b00, 2'b11};
		u_host.wr(16'h0AE0);
		foreach (b[i]) begin
			if (i == 3)
				u_host.wr(16'h0020);
			rcv({22'h0, b[i], 8'h00}, lv);
			chk(lv, e[i]);
		end
		$display("test decoder done");
	endtask

	task automatic t_lbl();
		u_host.wr(16'h0022);
		u_host.tx(16'h00AA, 16'h00BB);
		chk(tv, 1'b0);
		u_host.wr(16'h0020);
		u_host.wr(16'h0022);
		u_host.rx(1'b0, 1'b0, q);
		chk(q, 16'h00AA);
		u_host.rx(1'b0, 1'b1, q);
		chk(q, 16'h00BB);
		u_host.wr(16'h0024);
		rcv(32'h000000AA, lv);
		chk(lv, 2'b11);
		rcv(32'h00000055, lv);
		chk(lv, 2'b10);
		$display("test labels done");
	endtask

	task automatic t_rxrd();
		@(posedge i_clk_sys) #5;
		hw1 = 32'h80004201;
		hw2 = 32'h12345678;
		u_host.wr(16'h0020);
		u_host.rx(1'b0, 1'b0, q);
		chk(q, 16'h1180);
		u_host.rx(1'b1, 1'b0, q);
		chk(q, 16'h0002);
		u_host.tx(16'h1180, 16'h0002);
		chk(tw, 32'h80004201);
		u_host.wr(16'h8020);
		u_host.rx(1'b0, 1'b0, q);
		chk(q, 16'h4201);
		u_host.rx(1'b1, 1'b1, q);
		chk(q, 16'h1234);
		$display("test receive read done");
	endtask

	initial begin
		i_clk_sys = 1'b0;
		forever #25 i_clk_sys = ~i_clk_sys;
	end

	always @(posedge i_clk_sys) begin
		cyc++;
		if (cyc == 10000) begin
			miscompares++;
			report_and_stop();
		end
	end

	initial begin
		i_rst_n = 1'b0;
		{c1, c2, ct, w1, w2, hw1, hw2} = '0;
		{eos1, eos2, l1o, l1z, l2o, l2z, to, tz} = 8'h00;
		repeat (20) @(posedge i_clk_sys);
		#5 i_rst_n = 1'b1;
		t_reset();
		t_cfg();
		t_stat();
		t_tx();
		t_rate();
		t_loop();
		t_dec();
		t_lbl();
		t_rxrd();
		report_and_stop();
	end
endmodule

// >>> tb/arcs_regs_sva.sv
/*
 * Port checker of the configuration and status register block.
 * Assumes a bind onto arcs_regs and one clock with async low reset.
 */
`timescale 1ns/10ps

module arcs_regs_sva #(
	parameter int CNT_W = 6
) (
	input wire logic i_clk_sys, // Clock
	input wire logic i_rst_n, // Reset, low
	input wire logic [15:0] i_bus_data, // Host bus in
	input wire logic [15:0] o_bus_data, // Host bus out
	input wire logic o_bus_oe_n, // Bus drive, low
	input wire logic i_config_write_strobe_n, // Config write
	input wire logic i_register_read_strobe_n, // Register read
	input wire logic i_byte_select, // Byte select
	input wire logic [CNT_W-1:0] i_rx1_count, // Rx1 level
	input wire logic [CNT_W-1:0] i_tx_count, // Tx level
	input wire logic o_rx1_ready_pin_n, // Rx1 ready pin
	input wire logic o_tx_half_pin_n, // Tx half pin
	input wire logic [31:0] o_tx_word, // Tx word
	input wire logic o_tx_word_valid, // Tx word strobe
	input wire logic o_tx_clk_en, // Tx bit enable
	input wire logic o_tx_slow_slope, // Tx slow slope
	input wire logic i_tx_out_one, // Tx ones
	input wire logic o_rx1_one, // Rx1 ones in
	input wire logic i_rx1_eos, // Rx1 word done
	input wire logic [31:0] i_rx1_rcv_word, // Rx1 new word
	input wire logic o_rx1_load // Rx1 accepted
);
	logic [15:0] sh;
	logic [6:0] gap;
	logic clean;
	logic slq;

	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (!i_rst_n);

	// Shadow config and tx enable spacing
	always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
		if (!i_rst_n) begin
			sh <= 16'h0000;
			gap <= 7'h00;
			clean <= 1'b0;
			slq <= 1'b0;
		end else begin
			if (!i_config_write_strobe_n) begin
				sh <= i_bus_data;
			end
			slq <= o_tx_slow_slope;
			gap <= o_tx_clk_en ? 7'h01 : gap + 7'h01;
			clean <= (o_tx_clk_en | clean) & (o_tx_slow_slope == slq);
		end
	end

	chk_cfg_read: assert property (
		!i_register_read_strobe_n && i_byte_select && i_config_write_strobe_n
		|=> !o_bus_oe_n && o_bus_data == sh)
		else $error("config readback wrong");
	chk_stat_upper: assert property (
		!i_register_read_strobe_n && !i_byte_select
		|=> !o_bus_oe_n && o_bus_data[15:9] == 7'h00)
		else $error("status upper bits not zero");
	chk_rx1_ready: assert property (
		1'b1 |=> o_rx1_ready_pin_n == ($past(i_rx1_count) == 0))
		else $error("rx1 ready pin wrong");
	chk_tx_half: assert property (
		1'b1 |=> o_tx_half_pin_n == ($past(i_tx_count) < 16))
		else $error("tx half pin wrong");
	chk_tx_rate: assert property (
		o_tx_clk_en && clean && o_tx_slow_slope == slq
		|-> gap == (slq ? 7'h50 : 7'h0A))
		else $error("tx enable spacing wrong");
	chk_self_loop: assert property (
		!sh[5] |=> o_rx1_one == $past(i_tx_out_one))
		else $error("loopback not routed");
	chk_tx_parity: assert property (
		o_tx_word_valid && sh[4] |-> (^o_tx_word) != sh[12])
		else $error("tx parity wrong");
	chk_rx1_reject: assert property (
		i_rx1_eos && sh[6] && i_rx1_rcv_word[9:8] != {sh[8], sh[7]}
		|-> ##2 !o_rx1_load)
		else $error("rx1 word not rejected");
	chk_rx1_accept: assert property (
		i_rx1_eos && !sh[1] && !sh[2]
		&& (!sh[6] || i_rx1_rcv_word[9:8] == {sh[8], sh[7]})
		|-> ##2 o_rx1_load)
		else $error("rx1 word not loaded");

	cover property (o_tx_word_valid && sh[4]);
	cover property (o_rx1_load && sh[6]);
	cover property (!o_bus_oe_n && i_byte_select);
endmodule

bind arcs_regs arcs_regs_sva #(.CNT_W(CNT_W)) u_sva (.*);
